// >>> pkg/trgseq_defs.vh
// Constants for the peripheral trigger sequencer: register offsets,
// field positions, reset values and step command codes.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
`ifndef TRGSEQ_DEFS_VH
`define TRGSEQ_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TS_OFF_CTRL     12'h000
`define TS_OFF_STAT     12'h004
`define TS_OFF_IRQ_STAT 12'h008
`define TS_OFF_IRQ_CLR  12'h00c
`define TS_OFF_IRQ_EN   12'h010
`define TS_OFF_T0LIM    12'h014
`define TS_OFF_T1LIM    12'h018
`define TS_OFF_C0LIM    12'h01c
`define TS_OFF_C1LIM    12'h020
`define TS_OFF_ADJ      12'h024
`define TS_OFF_LIT0     12'h028
`define TS_OFF_WDLIM    12'h02c
`define TS_OFF_QUE0     12'h040

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define TS_CTRL_EN      0
`define TS_CTRL_STRT    1
`define TS_CTRL_SSTEP   2
`define TS_CTRL_CLKSEL  4

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define TS_IRQ_W        7
`define TS_IRQ_STEP     4
`define TS_IRQ_WDT      5
`define TS_IRQ_ADD      6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TS_LIM_RST      16'h0000
`define TS_WDLIM_RST    16'hffff

// ----------------------------------------------------------------
// Step command codes (upper nibble of step byte)
// ----------------------------------------------------------------
`define TS_CMD_CTRL     4'h0
`define TS_CMD_ADD      4'h1
`define TS_CMD_WHI      4'h4
`define TS_CMD_WLO      4'h5
`define TS_CMD_IRQ      4'h7
`define TS_CMD_TRIG0    4'h8
`define TS_CMD_TRIG1    4'h9
`define TS_CMD_JMP0     4'ha
`define TS_CMD_JMP1     4'hb
`define TS_CMD_JC00     4'hc
`define TS_CMD_JC01     4'hd
`define TS_CMD_JC10     4'he
`define TS_CMD_JC11     4'hf

// Control options
`define TS_OPT_T0WAIT   4'h8
`define TS_OPT_T1WAIT   4'h9

`endif

// >>> design/trgseq_edge.v
// Trigger input conditioner: three-stage synchroniser and edge detect.
// Assumes async inputs from other peripherals; one hclk domain.
`timescale 1ns/1ps
module trgseq_edge #(
  parameter W = 16
) (
  input  wire         hclk,     // Clock
  input  wire         hresetn,  // Async reset, active low
  input  wire         ce,       // Clock enable
  input  wire [W-1:0] din,      // Raw trigger inputs
  output wire [W-1:0] rise,     // Rising edge seen, one cycle
  output wire [W-1:0] fall      // Falling edge seen, one cycle
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  // ------------------------------------------------------------
  // Synchroniser; level moves only when stages two and three agree
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  // Edges from the agreed level against its stable next value
  assign rise = ~lvl_q & s2_q & s3_q;
  assign fall = lvl_q & ~s2_q & ~s3_q;

endmodule // trgseq_edge

// >>> design/trgseq_top.v
// Peripheral trigger sequencer: AHB-Lite registers, eight-step queue,
// two timers, two limit counters, watchdog, trigger and interrupt outputs.
// Assumes trigger inputs asynchronous; bus and engine on hclk.
`timescale 1ns/1ps
`include "trgseq_defs.vh"
module trgseq_top #(
  parameter NQ = 8
) (
  input  wire        hclk,       // Bus clock
  input  wire        hresetn,    // Async reset, active low
  input  wire        clk_en,     // Clock enable, freezes state
  input  wire [3:0]  clk_src,    // Alternate clock ticks, sync
  input  wire        hsel,       // Slave select
  input  wire [11:0] haddr,      // Byte address
  input  wire [1:0]  htrans,     // Transfer type
  input  wire        hwrite,     // Write not read
  input  wire [2:0]  hsize,      // Transfer size
  input  wire        hready,     // Bus ready in
  input  wire [31:0] hwdata,     // Write data
  output reg  [31:0] hrdata,     // Read data
  output reg         hreadyout,  // Slave ready
  output reg         hresp,      // Always OKAY
  input  wire [15:0] trig_in,    // Peripheral triggers
  output reg  [31:0] trig_out,   // Trigger pulses
  output reg  [3:0]  irq_req,    // Step interrupt pulses
  output reg         irq         // Level interrupt
);

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  localparam ST_FETCH = 2'd0;
  localparam ST_WAIT  = 2'd1;
  localparam ST_TMR   = 2'd2;

  reg [7:0]  ctrl_q;
  reg [15:0] t0lim_q, t1lim_q, c0lim_q, c1lim_q;
  reg [15:0] adj_q, lit0_q, wdlim_q;
  reg [15:0] tmr0_q, tmr1_q, cnt0_q, cnt1_q, wdt_q;
  reg [7:0]  que_q [0:NQ-1];
  reg [2:0]  qptr_q;
  reg [1:0]  st_q;
  reg [7:0]  ista_q, ien_q;
  reg [3:0]  wopt_q;
  reg        wpol_q;
  reg        tsel_q;
  reg        stall_q;
  reg        ap_wr_q, ap_rd_q;
  reg [11:0] ap_addr_q;
  reg [7:0]  ev;
  reg [7:0]  clr;

  wire [15:0] rise, fall;
  wire        running = ctrl_q[`TS_CTRL_EN] & ctrl_q[`TS_CTRL_STRT];
  wire [7:0]  step    = que_q[qptr_q];
  wire [3:0]  cmd     = step[7:4];
  wire [3:0]  opt     = step[3:0];
  wire        tick    = clk_src[ctrl_q[`TS_CTRL_CLKSEL+1:`TS_CTRL_CLKSEL]];
  wire        go      = clk_en & tick & running & ~stall_q;

  // Decoded register index used by the limit write path only
  function [4:0] reg_idx;
    input [11:0] a;
    begin
      reg_idx = a[6:2];
    end
  endfunction

  // Trigger conditioning for all peripheral inputs
  trgseq_edge #(.W(16)) u_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (clk_en),
    .din     (trig_in),
    .rise    (rise),
    .fall    (fall)
  );

  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_addr_q <= 12'h000;
    end else if (clk_en && hready) begin
      ap_wr_q   <= hsel & htrans[1] & hwrite;
      ap_rd_q   <= hsel & htrans[1] & ~hwrite;
      ap_addr_q <= haddr;
    end
  end

  // Zero wait states; error response never used
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux, registered so data is valid in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `TS_OFF_CTRL:     hrdata <= {24'h000000, ctrl_q};
        `TS_OFF_STAT:     hrdata <= {16'h0000, cnt0_q[7:0], 3'b000, qptr_q, st_q};
        `TS_OFF_IRQ_STAT: hrdata <= {24'h000000, ista_q};
        `TS_OFF_IRQ_EN:   hrdata <= {24'h000000, ien_q};
        `TS_OFF_T0LIM:    hrdata <= {16'h0000, t0lim_q};
        `TS_OFF_T1LIM:    hrdata <= {16'h0000, t1lim_q};
        `TS_OFF_C0LIM:    hrdata <= {16'h0000, c0lim_q};
        `TS_OFF_C1LIM:    hrdata <= {16'h0000, c1lim_q};
        `TS_OFF_ADJ:      hrdata <= {16'h0000, adj_q};
        `TS_OFF_LIT0:     hrdata <= {16'h0000, lit0_q};
        `TS_OFF_WDLIM:    hrdata <= {16'h0000, wdlim_q};
        default: begin
          if (haddr[11:5] == 7'h02)
            hrdata <= {24'h000000, que_q[haddr[4:2]]};
          else
            hrdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Software registers; limits locked while running
  // ------------------------------------------------------------
  wire wr_lim = ap_wr_q & ~running;
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= 8'h00;
      t0lim_q <= `TS_LIM_RST;
      t1lim_q <= `TS_LIM_RST;
      c0lim_q <= `TS_LIM_RST;
      c1lim_q <= `TS_LIM_RST;
      adj_q   <= `TS_LIM_RST;
      lit0_q  <= `TS_LIM_RST;
      wdlim_q <= `TS_WDLIM_RST;
      ien_q   <= 8'h00;
      for (i = 0; i < NQ; i = i + 1)
        que_q[i] <= 8'h00;
    end else if (clk_en) begin
      if (ap_wr_q && ap_addr_q == `TS_OFF_CTRL)
        ctrl_q <= hwdata[7:0];
      if (ap_wr_q && ap_addr_q == `TS_OFF_IRQ_EN)
        ien_q <= hwdata[7:0];
      if (wr_lim && ap_addr_q == `TS_OFF_ADJ)
        adj_q <= hwdata[15:0];
      if (wr_lim && ap_addr_q == `TS_OFF_WDLIM)
        wdlim_q <= hwdata[15:0];
      if (wr_lim && ap_addr_q[11:5] == 7'h02)
        que_q[ap_addr_q[4:2]] <= hwdata[7:0];
      // Add step targets; only reachable while running
      if (go && st_q == ST_FETCH && cmd == `TS_CMD_ADD) begin
        case (opt)
          4'h0: t0lim_q <= t0lim_q + adj_q;
          4'h1: t1lim_q <= t1lim_q + adj_q;
          4'h2: c0lim_q <= c0lim_q + adj_q;
          4'h3: c1lim_q <= c1lim_q + adj_q;
          4'h4: lit0_q  <= lit0_q + adj_q;
          default: ;
        endcase
      end else if (wr_lim) begin
        case (reg_idx(ap_addr_q))
          reg_idx(`TS_OFF_T0LIM): t0lim_q <= hwdata[15:0];
          reg_idx(`TS_OFF_T1LIM): t1lim_q <= hwdata[15:0];
          reg_idx(`TS_OFF_C0LIM): c0lim_q <= hwdata[15:0];
          reg_idx(`TS_OFF_C1LIM): c1lim_q <= hwdata[15:0];
          reg_idx(`TS_OFF_LIT0):  lit0_q  <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Step engine
  // ------------------------------------------------------------
  wire t0_done = (tmr0_q >= t0lim_q);
  wire t1_done = (tmr1_q >= t1lim_q);
  wire wsat    = wpol_q ? fall[wopt_q] : rise[wopt_q];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= ST_FETCH;
      qptr_q   <= 3'd0;
      tmr0_q   <= 16'h0000;
      tmr1_q   <= 16'h0000;
      cnt0_q   <= 16'h0000;
      cnt1_q   <= 16'h0000;
      wopt_q   <= 4'h0;
      wpol_q   <= 1'b0;
      tsel_q   <= 1'b0;
      stall_q  <= 1'b0;
      trig_out <= 32'h0000_0000;
      irq_req  <= 4'h0;
      ev       <= 8'h00;
    end else if (clk_en) begin
      trig_out <= 32'h0000_0000;
      irq_req  <= 4'h0;
      ev       <= 8'h00;
      // Single-step: hold after each step until software clears it
      if (!ctrl_q[`TS_CTRL_SSTEP] || !running)
        stall_q <= 1'b0;
      if (!running) begin
        st_q   <= ST_FETCH;
        qptr_q <= 3'd0;
      end else if (go) begin
        case (st_q)
          ST_FETCH: begin
            ev[`TS_IRQ_STEP] <= ctrl_q[`TS_CTRL_SSTEP];
            stall_q <= ctrl_q[`TS_CTRL_SSTEP];
            qptr_q  <= qptr_q + 3'd1;
            case (cmd)
              `TS_CMD_CTRL: begin
                if (opt == `TS_OPT_T0WAIT || opt == `TS_OPT_T1WAIT) begin
                  tsel_q <= opt[0];
                  tmr0_q <= 16'h0000;
                  tmr1_q <= 16'h0000;
                  st_q   <= ST_TMR;
                  qptr_q <= qptr_q;
                end
              end
              `TS_CMD_WHI, `TS_CMD_WLO: begin
                wopt_q <= opt;
                wpol_q <= cmd[0];
                st_q   <= ST_WAIT;
                qptr_q <= qptr_q;
              end
              `TS_CMD_IRQ: begin
                if (!opt[3] && !opt[2]) begin
                  irq_req[opt[1:0]] <= 1'b1;
                  ev[opt[1:0]]      <= 1'b1;
                end
              end
              `TS_CMD_TRIG0, `TS_CMD_TRIG1:
                trig_out[{cmd[0], opt}] <= 1'b1;
              `TS_CMD_JMP0, `TS_CMD_JMP1:
                qptr_q <= opt[2:0];
              `TS_CMD_JC00, `TS_CMD_JC01: begin
                if (cnt0_q == c0lim_q)
                  cnt0_q <= 16'h0000;
                else begin
                  cnt0_q <= cnt0_q + 16'h0001;
                  qptr_q <= opt[2:0];
                end
              end
              `TS_CMD_JC10, `TS_CMD_JC11: begin
                if (cnt1_q == c1lim_q)
                  cnt1_q <= 16'h0000;
                else begin
                  cnt1_q <= cnt1_q + 16'h0001;
                  qptr_q <= opt[2:0];
                end
              end
              default: ;
            endcase
          end
          ST_WAIT: begin
            if (wsat) begin
              st_q   <= ST_FETCH;
              qptr_q <= qptr_q + 3'd1;
            end
          end
          ST_TMR: begin
            if (tsel_q ? t1_done : t0_done) begin
              st_q   <= ST_FETCH;
              qptr_q <= qptr_q + 3'd1;
            end else if (tsel_q)
              tmr1_q <= tmr1_q + 16'h0001;
            else
              tmr0_q <= tmr0_q + 16'h0001;
          end
          default: st_q <= ST_FETCH;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Watchdog: counts while parked in a wait state
  // ------------------------------------------------------------
  reg wdt_ev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_q  <= 16'h0000;
      wdt_ev <= 1'b0;
    end else if (clk_en) begin
      wdt_ev <= 1'b0;
      if (!running || st_q == ST_FETCH)
        wdt_q <= 16'h0000;
      else if (wdt_q == wdlim_q) begin
        wdt_q  <= 16'h0000;
        wdt_ev <= 1'b1;
      end else
        wdt_q <= wdt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Sticky interrupt status, set wins over clear
  // ------------------------------------------------------------
  always @* begin
    clr = 8'h00;
    if (ap_wr_q && ap_addr_q == `TS_OFF_IRQ_CLR)
      clr = hwdata[7:0];
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ista_q <= 8'h00;
      irq    <= 1'b0;
    end else if (clk_en) begin
      ista_q <= (ista_q & ~clr) | ev | {2'b00, wdt_ev, 5'b00000};
      irq    <= |(ista_q & ien_q);
    end
  end

endmodule // trgseq_top

// >>> test/trgseq_checker.sv
// Checker for the trigger sequencer: bus answers, pulse outputs, freeze.
// Sees only the top module's ports; bound from the testbench top file.
`timescale 1ns/1ps
module trgseq_checker (
  input logic        hclk,       // Clock
  input logic        hresetn,    // Async reset, active low
  input logic        clk_en,     // Clock enable
  input logic        hsel,       // Slave select
  input logic [11:0] haddr,      // Byte address
  input logic [1:0]  htrans,     // Transfer type
  input logic        hwrite,     // Write not read
  input logic        hready,     // Bus ready in
  input logic [31:0] hrdata,     // Read data
  input logic        hreadyout,  // Slave ready
  input logic        hresp,      // Response
  input logic [31:0] trig_out,   // Trigger pulses
  input logic [3:0]  irq_req,    // Step interrupt pulses
  input logic        irq         // Level interrupt
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  sequence rd_addr;
    hsel && htrans[1] && hready && clk_en && !hwrite;
  endsequence
  // Gap between the last limit and the queue, and above the queue
  sequence rd_unmapped;
    rd_addr ##0 (haddr >= 12'h060 || (haddr >= 12'h030 && haddr < 12'h040));
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  ready_always_a: assert property (hreadyout) else $error("slave stalled");
  resp_okay_a: assert property (!hresp) else $error("error response");
  unmapped_zero_a: assert property (rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_holds_a: assert property (!(hsel && htrans[1] && hready && clk_en && !hwrite)
    |=> $stable(hrdata))
    else $error("read data moved without a read");
  trig_single_a: assert property ($onehot0(trig_out))
    else $error("several triggers at once");
  irq_single_a: assert property ($onehot0(irq_req))
    else $error("several step interrupts at once");
  one_step_a: assert property (trig_out != 32'h0 |-> irq_req == 4'h0)
    else $error("two steps in one cycle");
  // Clock enable low must hold every registered output
  freeze_hold_a: assert property (!clk_en |=> $stable(trig_out) && $stable(irq_req)
    && $stable(irq) && $stable(hrdata))
    else $error("outputs moved while frozen");
endmodule // trgseq_checker

// >>> test/trgseq_periph.sv
// Peripheral side model: drives trigger lines, counts sequencer pulses.
// Assumes one clock; lines change only just after a rising edge.
`timescale 1ns/1ps
module trgseq_periph (
  input  logic        hclk,      // Clock
  input  logic [31:0] trig_out,  // Sequencer trigger pulses
  input  logic [3:0]  irq_req,   // Sequencer interrupt pulses
  output logic [15:0] trig_in    // Peripheral event lines
);
  integer trig_cnt [0:31];
  integer irq_cnt  [0:3];
  integer i;

  // Idle lines low, counters empty
  initial begin
    trig_in = 16'h0000;
    for (i = 0; i < 32; i++) begin
      trig_cnt[i] = 0;
      if (i < 4) irq_cnt[i] = 0;
    end
  end

  // Count every pulse seen, so duplicates are caught too
  always @(posedge hclk) begin
    for (int k = 0; k < 32; k++) begin
      if (trig_out[k] === 1'b1) trig_cnt[k] = trig_cnt[k] + 1;
      if (k < 4 && irq_req[k] === 1'b1) irq_cnt[k] = irq_cnt[k] + 1;
    end
  end

  // One peripheral event line changes after an edge
  task set_in(input integer idx, input logic val);
    @(posedge hclk);
    trig_in[idx] <= val;
  endtask
endmodule // trgseq_periph

// >>> test/trgseq_tb_top.sv
// Testbench: programs the queue over AHB-Lite and judges the outputs.
// Assumes the peripheral model and the bound checker beside the design.
`timescale 1ns/1ps
`include "trgseq_defs.vh"
module trgseq_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic        hwrite;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  clk_src;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire  [31:0] trig_out;
  wire         hreadyout;
  wire         hresp;
  wire         irq;
  wire  [3:0]  irq_req;
  wire  [15:0] trig_in;
  integer      n_mismatch;
  integer      check_count;
  // Trig 3, wait rise 2, irq 1, reserved, add T0, wait fall 2, trig 5, park
  logic [7:0]  prog [0:7] = '{8'h83, 8'h42, 8'h71, 8'h60, 8'h10, 8'h52, 8'h85, 8'ha7};
  // Timer one wait, trig 0, loop to 1 until counter 0 hits its limit, wait rise 2
  logic [7:0]  prog2 [0:3] = '{8'h09, 8'h80, 8'hc1, 8'h42};

  trgseq_top u_trgseq_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .clk_src(clk_src), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in), .trig_out(trig_out),
    .irq_req(irq_req), .irq(irq));
  trgseq_periph u_trgseq_periph (.hclk(hclk), .trig_out(trig_out), .irq_req(irq_req),
    .trig_in(trig_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  always #5 hclk = ~hclk;

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single word transfer; waits on the slave, no fixed latency assumed
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
              input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x & m);
  endtask
  // Bounded wait for a pulse count of the model
  task wait_cnt(input bit is_irq, input integer b, input integer n);
    for (int i = 0; i < 60; i++) begin
      if ((is_irq ? u_trgseq_periph.irq_cnt[b] : u_trgseq_periph.trig_cnt[b]) == n) break;
      @(posedge hclk);
    end
    chk(is_irq ? "irq_req count" : "trig_out count", n,
        is_irq ? u_trgseq_periph.irq_cnt[b] : u_trgseq_periph.trig_cnt[b]);
  endtask
  task wait_irq(input logic exp);
    for (int i = 0; i < 20 && irq !== exp; i++) @(posedge hclk);
    chk("irq level", {31'h0, exp}, {31'h0, irq});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset_vals;
    rd_chk("t0 limit reset", `TS_OFF_T0LIM, 32'hffffffff, 32'h0);
    rd_chk("t1 limit reset", `TS_OFF_T1LIM, 32'hffffffff, 32'h0);
    rd_chk("unmapped read", 12'h060, 32'hffffffff, 32'h0);
  endtask
  task t_limit_rw;
    wr(`TS_OFF_T1LIM, 32'h0000beef);
    rd_chk("t1 limit rw", `TS_OFF_T1LIM, 32'h0000ffff, 32'h0000beef);
    wr(`TS_OFF_ADJ, 32'h00000011);
  endtask
  task t_run_program;
    for (int k = 0; k < 8; k++) wr(12'(`TS_OFF_QUE0 + 4 * k), {24'h0, prog[k]});
    wr(`TS_OFF_IRQ_EN, 32'h2);
    wr(`TS_OFF_CTRL, 32'h3);
    wait_cnt(0, 3, 1);
    wr(`TS_OFF_T0LIM, 32'h00001234);
    clk_en <= 1'b0;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    repeat (12) @(posedge hclk);
    chk("trig 5 blocked", 0, u_trgseq_periph.trig_cnt[5]);
    u_trgseq_periph.set_in(2, 1'b1);
    wait_cnt(1, 1, 1);
    wait_irq(1'b1);
    rd_chk("irq status", `TS_OFF_IRQ_STAT, 32'h2, 32'h2);
    u_trgseq_periph.set_in(2, 1'b0);
    wait_cnt(0, 5, 1);
    chk("trig 3 once", 1, u_trgseq_periph.trig_cnt[3]);
  endtask
  task t_irq_clear;
    wr(`TS_OFF_IRQ_CLR, 32'h2);
    wait_irq(1'b0);
    rd_chk("irq status clear", `TS_OFF_IRQ_STAT, 32'h2, 32'h0);
  endtask
  task t_stop_readback;
    wr(`TS_OFF_CTRL, 32'h1);
    rd_chk("t0 after add", `TS_OFF_T0LIM, 32'h0000ffff, 32'h00000011);
    wr(`TS_OFF_T0LIM, 32'h00000abc);
    rd_chk("t0 idle rw", `TS_OFF_T0LIM, 32'h0000ffff, 32'h00000abc);
  endtask
  // Clock select, timer wait, counter loop, watchdog and single step
  task t_timer_loop;
    wr(`TS_OFF_T1LIM, 32'h00000014);
    wr(`TS_OFF_C0LIM, 32'h00000002);
    wr(`TS_OFF_WDLIM, 32'h00000040);
    for (int k = 0; k < 4; k++) wr(12'(`TS_OFF_QUE0 + 4 * k), {24'h0, prog2[k]});
    clk_src <= 4'hd;
    wr(`TS_OFF_CTRL, 32'h13);
    repeat (30) @(posedge hclk);
    chk("source one idle", 0, u_trgseq_periph.trig_cnt[0]);
    clk_src <= 4'hf;
    repeat (10) @(posedge hclk);
    chk("timer one wait", 0, u_trgseq_periph.trig_cnt[0]);
    wait_cnt(0, 0, 3);
    rd_chk("no watchdog yet", `TS_OFF_IRQ_STAT, 32'h30, 32'h0);
    repeat (80) @(posedge hclk);
    rd_chk("watchdog status", `TS_OFF_IRQ_STAT, 32'h30, 32'h20);
    wr(`TS_OFF_CTRL, 32'h1);
    wr(`TS_OFF_CTRL, 32'h17);
    repeat (40) @(posedge hclk);
    chk("single step stall", 3, u_trgseq_periph.trig_cnt[0]);
    rd_chk("step status", `TS_OFF_IRQ_STAT, 32'h10, 32'h10);
    wr(`TS_OFF_CTRL, 32'h1);
  endtask

  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    clk_src = 4'hf;
    hwdata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_vals();
    t_limit_rw();
    t_run_program();
    t_irq_clear();
    t_stop_readback();
    t_timer_loop();
    report_and_stop();
  end
  // Whole run is a few hundred cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch = n_mismatch + 1;
    report_and_stop();
  end
endmodule // trgseq_tb_top

bind trgseq_top trgseq_checker u_trgseq_checker (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .trig_out(trig_out), .irq_req(irq_req), .irq(irq));
